// ==== rtl/osd_cmd_pkg.sv ====
package osd_cmd_pkg;
    // Identifier patterns
    localparam logic [7:0] ID_MAIN_ADDR   = 8'h80;
    localparam logic [7:0] ID_SUB_ADDR    = 8'h84;
    localparam logic [5:0] ID_MAIN_CHAR   = 6'h24;
    localparam logic [5:0] ID_SUB_CHAR    = 6'h25;
    localparam logic [7:0] ID_SYS_CTRL    = 8'ha0;
    localparam logic [7:0] ID_DISP_CTRL   = 8'ha1;
    localparam logic [7:0] ID_IO_POL1     = 8'ha2;
    localparam logic [7:0] ID_BACKDROP    = 8'ha3;
    localparam logic [7:0] ID_IO_POL2     = 8'ha4;
    localparam logic [7:0] ID_OUT_CTRL    = 8'ha5;
    localparam logic [7:0] ID_MAIN_VSTART = 8'hb0;
    localparam logic [6:0] ID_MAIN_HSTART = 7'h59;
    localparam logic [7:0] ID_SUB_VSTART  = 8'hb4;
    localparam logic [6:0] ID_SUB_HSTART  = 7'h5b;
    localparam logic [7:0] ID_SCR_VSTART  = 8'hb8;
    localparam logic [6:0] ID_SCR_HSTART  = 7'h5d;
    localparam logic [7:0] ID_MAGNIFY     = 8'hc0;
    localparam logic [7:0] ID_SIZE_LO     = 8'hc4;
    localparam logic [7:0] ID_SIZE_HI     = 8'hc8;
    localparam logic [7:0] ID_BOX_UPPER   = 8'hd0;
    localparam logic [7:0] ID_BOX_LOWER   = 8'hd4;
    localparam logic [7:0] ID_BOX_LO      = 8'hd8;
    localparam logic [7:0] ID_BOX_HI      = 8'hdc;
    localparam logic [5:0] ID_OUTLINE     = 6'h38;
    localparam logic [7:0] ID_OUTL_LO     = 8'he4;
    localparam logic [7:0] ID_OUTL_HI     = 8'he8;
    localparam logic [7:0] ID_PAL_PTR     = 8'hf0;
    localparam logic [6:0] ID_PAL_DATA    = 7'h7a;
    // Write modes of the character commands
    localparam logic [1:0] WM_SINGLE      = 2'h0;
    localparam logic [1:0] WM_FULL_REPEAT = 2'h1;
    localparam logic [1:0] WM_REPEAT_34   = 2'h2;
    localparam logic [1:0] WM_REPEAT_234  = 2'h3;
    // Code limits
    localparam logic [10:0] CODE_INT_MAX  = 11'h1ff;
    localparam logic [10:0] CODE_EXT_MAX  = 11'h7ff;
    // Pointer limits
    localparam logic [3:0] LINES_LOWRES   = 4'hd;
    localparam logic [3:0] LINES_WIDE     = 4'hf;
    localparam logic [5:0] COLS_LOWRES    = 6'h28;
    localparam logic [5:0] COLS_WIDE      = 6'h21;
    // Reset values
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [8:0]  RST_HSTART    = 9'h000;
    localparam logic [15:0] RST_MASK      = 16'h0000;
    localparam logic [15:0] RST_PTR       = 16'h0000;
    localparam logic [31:0] RST_CHAR      = 32'h0000_0000;
    // Host timing, for reference of the bench
    localparam real UNIT_TIME_US          = 4.2;
    localparam real SELECT_HIGH_US        = 1.0;
    localparam real SYS_CLK_MHZ           = 40.0;
    localparam int  UNIT_CYCLES           = int'(UNIT_TIME_US * SYS_CLK_MHZ);
    localparam int  SELECT_HIGH_CYCLES    = int'(SELECT_HIGH_US * SYS_CLK_MHZ);
    // Decoder states
    typedef enum logic [3:0] {
        ST_IDENT = 4'b0001,
        ST_DATA  = 4'b0010,
        ST_CHAR  = 4'b0100,
        ST_DONE  = 4'b1000
    } decode_state_t;
endpackage

// ==== rtl/osd_serial_command_decoder.sv ====
`timescale 1ns/100ps
module osd_serial_command_decoder
    import osd_cmd_pkg::*;
(
    // System
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Serial link pins
    input  wire logic         serialClk,
    input  wire logic         serialData,
    input  wire logic         selectN,
    // Display settings
    output logic [15:0]       mainWritePointer,
    output logic [15:0]       subWritePointer,
    output logic [7:0]        systemControl,
    output logic [7:0]        displayControl,
    output logic [7:0]        ioPolarityFirst,
    output logic [7:0]        backdropColour,
    output logic [7:0]        ioPolaritySecond,
    output logic [7:0]        outputControl,
    output logic [7:0]        mainVertStart,
    output logic [8:0]        mainHorizStart,
    output logic [7:0]        subVertStart,
    output logic [8:0]        subHorizStart,
    output logic [7:0]        screenVertStart,
    output logic [8:0]        screenHorizStart,
    output logic [7:0]        glyphMagnification,
    output logic [15:0]       sizeLineMask,
    output logic [7:0]        boxUpperStyle,
    output logic [7:0]        boxLowerStyle,
    output logic [15:0]       boxLineMask,
    output logic [7:0]        outlineControl,
    output logic [15:0]       outlineLineMask,
    output logic [7:0]        paletteWritePointer,
    // Character and palette write strobes
    output logic              charWrite,
    output logic              charIsSub,
    output logic [31:0]       charWord,
    output logic              charTransparent,
    output logic              paletteWrite,
    output logic [7:0]        paletteData
);
    import osd_cmd_pkg::*;

    logic [2:0] clkSync_reg;
    logic [1:0] dataSync_reg;
    logic [1:0] selSync_reg;
    logic       clkRise;
    logic       selLow;
    logic [7:0] shift_reg;
    logic [2:0] bitCount_reg;
    logic       byteDone;
    logic [7:0] rxByte;
    logic [7:0] ident_reg;
    logic [1:0] charIdx_reg;
    logic [31:0] charAcc_reg;
    logic       charCmd;
    logic [1:0] writeMode;
    logic [10:0] code;
    decode_state_t state_reg;

    // Two flops per pin; the third clock flop only feeds edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Idle-high like the pin, so leaving reset shows no false clock edge
            clkSync_reg  <= 3'h7;
            dataSync_reg <= 2'h0;
            selSync_reg  <= 2'h3;
        end else begin
            clkSync_reg  <= {clkSync_reg[1:0], serialClk};
            dataSync_reg <= {dataSync_reg[0], serialData};
            selSync_reg  <= {selSync_reg[0], selectN};
        end
    end

    assign clkRise = clkSync_reg[1] & ~clkSync_reg[2];
    assign selLow  = ~selSync_reg[1];

    // Byte assembly; counter clears whenever select is high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_reg    <= RST_BYTE;
            bitCount_reg <= 3'h0;
        end else if (!selLow) begin
            bitCount_reg <= 3'h0;
        end else if (clkRise) begin
            shift_reg    <= {dataSync_reg[1], shift_reg[7:1]};
            bitCount_reg <= bitCount_reg + 3'h1;
        end
    end

    assign byteDone = selLow && clkRise && (bitCount_reg == 3'h7);
    assign rxByte   = {dataSync_reg[1], shift_reg[7:1]};

    assign charCmd   = (ident_reg[7:2] == ID_MAIN_CHAR) || (ident_reg[7:2] == ID_SUB_CHAR);
    assign writeMode = ident_reg[1:0];

    // Framing state; only a select rise returns to identifier decoding
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDENT;
            ident_reg   <= RST_BYTE;
            charIdx_reg <= 2'h0;
        end else if (!selLow) begin
            state_reg   <= ST_IDENT;
            charIdx_reg <= 2'h0;
        end else if (byteDone) begin
            unique case (state_reg)
                ST_IDENT: begin
                    ident_reg   <= rxByte;
                    charIdx_reg <= 2'h0;
                    if (rxByte[7:2] == ID_MAIN_CHAR || rxByte[7:2] == ID_SUB_CHAR) begin
                        state_reg <= ST_CHAR;
                    end else begin
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (ident_reg[7:1] == ID_PAL_DATA && ident_reg[0]) begin
                        state_reg <= ST_DATA;
                    end else begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_CHAR: begin
                    if (charIdx_reg != 2'h3) begin
                        charIdx_reg <= charIdx_reg + 2'h1;
                    end else begin
                        unique case (writeMode)
                            WM_SINGLE:      state_reg <= ST_DONE;
                            WM_FULL_REPEAT: charIdx_reg <= 2'h0;
                            WM_REPEAT_34:   charIdx_reg <= 2'h2;
                            WM_REPEAT_234:  charIdx_reg <= 2'h1;
                        endcase
                    end
                end
                ST_DONE: state_reg <= ST_DONE;
            endcase
        end
    end

    // Character group assembly and write
    assign code = {charAcc_reg[10:8], rxByte};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            charAcc_reg     <= RST_CHAR;
            charWrite       <= 1'b0;
            charIsSub       <= 1'b0;
            charWord        <= RST_CHAR;
            charTransparent <= 1'b0;
        end else begin
            charWrite <= 1'b0;
            if (byteDone && state_reg == ST_CHAR && charCmd) begin
                unique case (charIdx_reg)
                    2'h0: charAcc_reg[31:24] <= ident_reg[2] ? RST_BYTE : rxByte;
                    2'h1: charAcc_reg[23:16] <= ident_reg[2] ? RST_BYTE : rxByte;
                    2'h2: charAcc_reg[15:8]  <= {2'h0, rxByte[5:0]};
                    2'h3: begin
                        charWrite <= 1'b1;
                        charIsSub <= ident_reg[2];
                        // Internal codes above the glyph store are folded back in range
                        charWord  <= {charAcc_reg[31:11],
                                      code[10:8] & (charAcc_reg[12] ? CODE_EXT_MAX[10:8]
                                                                    : CODE_INT_MAX[10:8]),
                                      rxByte};
                        charTransparent <= !charAcc_reg[12] && !charAcc_reg[11]
                                           && ((code & CODE_INT_MAX) == CODE_INT_MAX);
                    end
                endcase
            end
        end
    end

    // Data byte commands; palette data with identifier bit 0 set accepts repeated bytes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mainWritePointer    <= RST_PTR;
            subWritePointer     <= RST_PTR;
            systemControl       <= RST_BYTE;
            displayControl      <= RST_BYTE;
            ioPolarityFirst     <= RST_BYTE;
            backdropColour      <= RST_BYTE;
            ioPolaritySecond    <= RST_BYTE;
            outputControl       <= RST_BYTE;
            mainVertStart       <= RST_BYTE;
            mainHorizStart      <= RST_HSTART;
            subVertStart        <= RST_BYTE;
            subHorizStart       <= RST_HSTART;
            screenVertStart     <= RST_BYTE;
            screenHorizStart    <= RST_HSTART;
            glyphMagnification  <= RST_BYTE;
            sizeLineMask        <= RST_MASK;
            boxUpperStyle       <= RST_BYTE;
            boxLowerStyle       <= RST_BYTE;
            boxLineMask         <= RST_MASK;
            outlineControl      <= RST_BYTE;
            outlineLineMask     <= RST_MASK;
            paletteWritePointer <= RST_BYTE;
            paletteWrite        <= 1'b0;
            paletteData         <= RST_BYTE;
        end else begin
            paletteWrite <= 1'b0;
            if (byteDone && state_reg == ST_DATA) begin
                if (ident_reg[7:2] == ID_MAIN_ADDR[7:2]) begin
                    // Line saturates at the wide-format limit, column at the low-resolution limit
                    mainWritePointer <= {6'h00,
                        ({ident_reg[1:0], rxByte[7:6]} >= LINES_WIDE)
                            ? LINES_WIDE - 4'h1 : {ident_reg[1:0], rxByte[7:6]},
                        (rxByte[5:0] >= COLS_LOWRES)
                            ? COLS_LOWRES - 6'h1 : rxByte[5:0]};
                end
                if (ident_reg == ID_SUB_ADDR) begin
                    subWritePointer <= {14'h0000, rxByte[6], rxByte[0]};
                end
                if (ident_reg == ID_SYS_CTRL)   systemControl <= rxByte;
                if (ident_reg == ID_DISP_CTRL)  displayControl <= rxByte;
                if (ident_reg == ID_IO_POL1)    ioPolarityFirst <= rxByte;
                if (ident_reg == ID_BACKDROP)   backdropColour <= {2'h0, rxByte[5:0]};
                if (ident_reg == ID_IO_POL2)    ioPolaritySecond <= rxByte;
                if (ident_reg == ID_OUT_CTRL)   outputControl <= {3'h0, rxByte[4:0]};
                if (ident_reg == ID_MAIN_VSTART) mainVertStart <= rxByte;
                if (ident_reg == ID_SUB_VSTART)  subVertStart <= rxByte;
                if (ident_reg == ID_SCR_VSTART)  screenVertStart <= rxByte;
                if (ident_reg[7:1] == ID_MAIN_HSTART) mainHorizStart <= {ident_reg[0], rxByte};
                if (ident_reg[7:1] == ID_SUB_HSTART)  subHorizStart <= {ident_reg[0], rxByte};
                if (ident_reg[7:1] == ID_SCR_HSTART)  screenHorizStart <= {ident_reg[0], rxByte};
                if (ident_reg == ID_MAGNIFY) glyphMagnification <= {4'h0, rxByte[3:0]};
                if (ident_reg == ID_SIZE_LO) sizeLineMask[7:0] <= rxByte;
                if (ident_reg == ID_SIZE_HI) sizeLineMask[15:8] <= rxByte;
                if (ident_reg == ID_BOX_LO)  boxLineMask[7:0] <= rxByte;
                if (ident_reg == ID_BOX_HI)  boxLineMask[15:8] <= rxByte;
                if (ident_reg == ID_OUTL_LO) outlineLineMask[7:0] <= rxByte;
                if (ident_reg == ID_OUTL_HI) outlineLineMask[15:8] <= rxByte;
                if (ident_reg == ID_BOX_UPPER) boxUpperStyle <= {rxByte[7:6], 1'b0, rxByte[4:0]};
                if (ident_reg == ID_BOX_LOWER) boxLowerStyle <= {rxByte[7:6], 1'b0, rxByte[4:0]};
                if (ident_reg[7:2] == ID_OUTLINE) outlineControl <= {ident_reg[1:0], 1'b0, rxByte[4:0]};
                if (ident_reg == ID_PAL_PTR) paletteWritePointer <= {3'h0, rxByte[4:0]};
                if (ident_reg[7:1] == ID_PAL_DATA) begin
                    paletteWrite <= 1'b1;
                    paletteData  <= rxByte;
                end
            end
        end
    end

    property p_select_high_frames;
        @(posedge sys_clk) disable iff (rst)
        selSync_reg[1] |=> (bitCount_reg == 3'h0 && state_reg == ST_IDENT);
    endproperty
    a_select_high_frames: assert property (p_select_high_frames)
        else $error("framing not cleared while select high");

    property p_ident_leaves;
        @(posedge sys_clk) disable iff (rst)
        (byteDone && state_reg == ST_IDENT) |=> (state_reg != ST_IDENT || !selLow);
    endproperty
    a_ident_leaves: assert property (p_ident_leaves)
        else $error("identifier byte not consumed");

    property p_char_continuous;
        @(posedge sys_clk) disable iff (rst)
        (state_reg == ST_CHAR && writeMode != WM_SINGLE && selLow && !byteDone)
            |=> state_reg == ST_CHAR;
    endproperty
    a_char_continuous: assert property (p_char_continuous)
        else $error("continuous mode left without select rise");

    property p_single_ends;
        @(posedge sys_clk) disable iff (rst)
        (byteDone && state_reg == ST_CHAR && charIdx_reg == 2'h3 && writeMode == WM_SINGLE)
            |=> state_reg == ST_DONE;
    endproperty
    a_single_ends: assert property (p_single_ends)
        else $error("single group did not end");

    property p_char_strobe;
        @(posedge sys_clk) disable iff (rst)
        (byteDone && state_reg == ST_CHAR && charIdx_reg == 2'h3)
            |=> (charWrite && charWord[7:0] == $past(rxByte));
    endproperty
    a_char_strobe: assert property (p_char_strobe)
        else $error("character write strobe missing");

    property p_sub_zero;
        @(posedge sys_clk) disable iff (rst)
        (charWrite && charIsSub) |-> charWord[31:16] == 16'h0000;
    endproperty
    a_sub_zero: assert property (p_sub_zero)
        else $error("sub character first bytes not zero");

    property p_hstart;
        @(posedge sys_clk) disable iff (rst)
        (byteDone && state_reg == ST_DATA && ident_reg[7:1] == ID_MAIN_HSTART)
            |=> mainHorizStart == {$past(ident_reg[0]), $past(rxByte)};
    endproperty
    a_hstart: assert property (p_hstart)
        else $error("horizontal start not loaded");

    property p_palette_strobe;
        @(posedge sys_clk) disable iff (rst)
        (byteDone && state_reg == ST_DATA && ident_reg[7:1] == ID_PAL_DATA)
            |=> (paletteWrite && paletteData == $past(rxByte));
    endproperty
    a_palette_strobe: assert property (p_palette_strobe)
        else $error("palette write missing");

    property p_output_zero;
        @(posedge sys_clk) disable iff (rst)
        outputControl[7:5] == 3'h0 && glyphMagnification[7:4] == 4'h0;
    endproperty
    a_output_zero: assert property (p_output_zero)
        else $error("reserved control bits set");

    property p_byte_count;
        @(posedge sys_clk) disable iff (rst)
        byteDone |=> bitCount_reg == 3'h0;
    endproperty
    a_byte_count: assert property (p_byte_count)
        else $error("bit counter not restarted after eighth bit");

    // Clamp keeps a stray host value from addressing outside the screen memory
    property p_pointer_clamp;
        @(posedge sys_clk) disable iff (rst)
        mainWritePointer[15:10] == 6'h00 && mainWritePointer[9:6] < LINES_WIDE
            && mainWritePointer[5:0] < COLS_LOWRES && subWritePointer[15:2] == 14'h0000;
    endproperty
    a_pointer_clamp: assert property (p_pointer_clamp)
        else $error("write pointer outside its range");

    property p_internal_code;
        @(posedge sys_clk) disable iff (rst)
        (charWrite && !charWord[12]) |-> charWord[10:9] == 2'h0;
    endproperty
    a_internal_code: assert property (p_internal_code)
        else $error("internal code above glyph store");

    property p_transparent;
        @(posedge sys_clk) disable iff (rst)
        charWrite |-> charTransparent == (!charWord[12] && !charWord[11]
                                          && charWord[10:0] == CODE_INT_MAX);
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("transparent flag wrong");

    property p_palette_single;
        @(posedge sys_clk) disable iff (rst)
        (paletteWrite && !ident_reg[0]) |-> state_reg == ST_DONE;
    endproperty
    a_palette_single: assert property (p_palette_single)
        else $error("single palette write left data open");

endmodule // osd_serial_command_decoder

// ==== verification/osd_host_model.sv ====
`timescale 1ns/100ps
module osd_host_model (
    // Serial link pins
    output logic serialClk,
    output logic serialData,
    output logic selectN
);
    initial begin
        serialClk  = 1'b1;
        serialData = 1'b1;
        selectN    = 1'b1;
    end
    // Sends nBits of the bytes; a count that is not a multiple of eight aborts mid-unit
    task automatic sendFrame(input logic [7:0] bytes[$], input int nBits);
        selectN = 1'b0;
        #400;
        for (int i = 0; i < nBits; i++) begin
            serialClk  = 1'b0;
            serialData = bytes[i / 8][i % 8];
            #100;
            serialClk = 1'b1;
            #100;
            if (i % 8 == 7) begin
                #2600;
            end
        end
        #400;
        selectN    = 1'b1;
        serialData = ~serialData;
        #1000;
    endtask
    // Released data line toggles so a stale level is never taken as a bit
    task automatic idleClocks();
        repeat (8) begin
            serialClk  = 1'b0;
            serialData = ~serialData;
            #100;
            serialClk = 1'b1;
            #100;
        end
    endtask
endmodule // osd_host_model

// ==== verification/osd_serial_command_decoder_bench.sv ====
`timescale 1ns/100ps
module osd_serial_command_decoder_bench;
    import osd_cmd_pkg::*;
    typedef struct packed {
        logic [7:0]  id;
        logic [7:0]  dat;
        logic [4:0]  sel;
        logic [15:0] exp;
    } row_t;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        serialClk, serialData, selectN, charWrite, charIsSub, charTransparent;
    logic        paletteWrite;
    logic [15:0] mainWritePointer, subWritePointer, sizeLineMask, boxLineMask, outlineLineMask;
    logic [7:0]  systemControl, displayControl, ioPolarityFirst, backdropColour, paletteData;
    logic [7:0]  ioPolaritySecond, outputControl, mainVertStart, subVertStart, screenVertStart;
    logic [7:0]  glyphMagnification, boxUpperStyle, boxLowerStyle, outlineControl;
    logic [7:0]  paletteWritePointer;
    logic [8:0]  mainHorizStart, subHorizStart, screenHorizStart;
    logic [31:0] charWord;
    logic [15:0] outs [22];
    logic [33:0] charSeen [$];
    logic [7:0]  palSeen [$];
    int          errors   = 0;
    int          compares = 0;
    row_t rows [27] = '{
        '{8'ha2, 8'h5a, 5'd2, 16'h005a}, '{8'ha3, 8'h2b, 5'd3, 16'h002b},
        '{8'ha4, 8'hc3, 5'd4, 16'h00c3}, '{8'ha5, 8'h1d, 5'd5, 16'h001d},
        '{8'hb0, 8'h11, 5'd6, 16'h0011}, '{8'hb4, 8'h22, 5'd8, 16'h0022},
        '{8'hb8, 8'h33, 5'd10, 16'h0033}, '{8'hb3, 8'h45, 5'd7, 16'h0145},
        '{8'hb6, 8'h77, 5'd9, 16'h0077}, '{8'hbb, 8'h80, 5'd11, 16'h0180},
        '{8'hc0, 8'h0e, 5'd12, 16'h000e}, '{8'hc4, 8'h34, 5'd13, 16'h0034},
        '{8'hc8, 8'h12, 5'd13, 16'h1234}, '{8'hd0, 8'hd5, 5'd14, 16'h00d5},
        '{8'hd4, 8'h9a, 5'd15, 16'h009a}, '{8'hd8, 8'haa, 5'd16, 16'h00aa},
        '{8'hdc, 8'h55, 5'd16, 16'h55aa}, '{8'he4, 8'h0f, 5'd17, 16'h000f},
        '{8'he8, 8'hf0, 5'd17, 16'hf00f}, '{8'hf0, 8'h1c, 5'd18, 16'h001c},
        '{8'h83, 8'h25, 5'd0, 16'h0325}, '{8'h80, 8'h3f, 5'd0, 16'h0027},
        '{8'h83, 8'hc0, 5'd0, 16'h0380}, '{8'h84, 8'h41, 5'd1, 16'h0003},
        '{8'ha0, 8'h30, 5'd19, 16'h0030}, '{8'ha1, 8'h5c, 5'd20, 16'h005c},
        '{8'he2, 8'h1b, 5'd21, 16'h009b}
    };
    logic [33:0] charExp [8] = '{34'h0_21f31541, 34'h2_000001ff, 34'h0_01021344,
        34'h0_01021566, 34'h0_01021344, 34'h0_01051788, 34'h0_3fa50112, 34'h1_00001344};
    logic [7:0]  palExp [3] = '{8'h12, 8'h34, 8'h56};

    always #12.5 sys_clk = ~sys_clk;

    assign outs = '{mainWritePointer, subWritePointer, 16'(ioPolarityFirst),
        16'(backdropColour), 16'(ioPolaritySecond), 16'(outputControl), 16'(mainVertStart),
        16'(mainHorizStart), 16'(subVertStart), 16'(subHorizStart), 16'(screenVertStart),
        16'(screenHorizStart), 16'(glyphMagnification), sizeLineMask, 16'(boxUpperStyle),
        16'(boxLowerStyle), boxLineMask, outlineLineMask, 16'(paletteWritePointer),
        16'(systemControl), 16'(displayControl), 16'(outlineControl)};

    // Strobes stand one cycle; sampled mid-cycle, clear of the edge that launches them
    always @(negedge sys_clk) begin
        if (charWrite === 1'b1) charSeen.push_back({charTransparent, charIsSub, charWord});
        if (paletteWrite === 1'b1) palSeen.push_back(paletteData);
    end

    osd_host_model hostU (.serialClk(serialClk), .serialData(serialData), .selectN(selectN));

    osd_serial_command_decoder dut_u (.sys_clk(sys_clk), .rst(rst), .serialClk(serialClk),
        .serialData(serialData), .selectN(selectN), .mainWritePointer(mainWritePointer),
        .subWritePointer(subWritePointer), .systemControl(systemControl),
        .displayControl(displayControl), .ioPolarityFirst(ioPolarityFirst),
        .backdropColour(backdropColour), .ioPolaritySecond(ioPolaritySecond),
        .outputControl(outputControl), .mainVertStart(mainVertStart),
        .mainHorizStart(mainHorizStart), .subVertStart(subVertStart),
        .subHorizStart(subHorizStart), .screenVertStart(screenVertStart),
        .screenHorizStart(screenHorizStart), .glyphMagnification(glyphMagnification),
        .sizeLineMask(sizeLineMask), .boxUpperStyle(boxUpperStyle),
        .boxLowerStyle(boxLowerStyle), .boxLineMask(boxLineMask),
        .outlineControl(outlineControl), .outlineLineMask(outlineLineMask),
        .paletteWritePointer(paletteWritePointer), .charWrite(charWrite),
        .charIsSub(charIsSub), .charWord(charWord), .charTransparent(charTransparent),
        .paletteWrite(paletteWrite), .paletteData(paletteData));

    task automatic checkVal(input logic [33:0] got, input logic [33:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Run-length guard; the host model itself never waits on the design
    initial begin
        #2000000;
        errors++;
        $display("wrong value at %0t: run limit reached", $time);
        stop_test();
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        foreach (rows[i]) begin
            hostU.sendFrame('{rows[i].id, rows[i].dat}, 16);
            checkVal(34'(outs[rows[i].sel]), 34'(rows[i].exp), "setting");
        end
        $display("test done: command table");
        hostU.sendFrame('{8'h91, 8'h21, 8'hf3, 8'h15, 8'h41, 8'h00, 8'h00, 8'h01, 8'hff}, 72);
        hostU.sendFrame('{8'h92, 8'h01, 8'h02, 8'h13, 8'h44, 8'h15, 8'h66}, 56);
        hostU.sendFrame('{8'h93, 8'h01, 8'h02, 8'h13, 8'h44, 8'h05, 8'h17, 8'h88}, 64);
        hostU.sendFrame('{8'h90, 8'h3f, 8'ha5, 8'h07, 8'h12, 8'h11, 8'h22, 8'h33, 8'h44}, 72);
        hostU.sendFrame('{8'h95, 8'hff, 8'hff, 8'h13, 8'h44}, 40);
        hostU.sendFrame('{8'hf5, 8'h12, 8'h34}, 24);
        hostU.sendFrame('{8'hf4, 8'h56, 8'h78}, 24);
        checkVal(34'(charSeen.size()), 34'd8, "character strobes");
        foreach (charExp[i]) checkVal(charSeen[i], charExp[i], "character word");
        checkVal(34'(palSeen.size()), 34'd3, "palette strobes");
        foreach (palExp[i]) checkVal(34'(palSeen[i]), 34'(palExp[i]), "palette data");
        $display("test done: character and palette writes");
        hostU.sendFrame('{8'ha2, 8'hff}, 13);
        checkVal(34'(ioPolarityFirst), 34'h5a, "partial unit");
        hostU.idleClocks();
        checkVal(34'(ioPolarityFirst), 34'h5a, "clocks while deselected");
        hostU.sendFrame('{8'ha2, 8'h3c}, 16);
        checkVal(34'(ioPolarityFirst), 34'h3c, "framing after abort");
        $display("test done: abort and deselect");
        @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        checkVal(34'({ioPolarityFirst, mainWritePointer}), 34'h0, "reset value");
        rst = 1'b0;
        hostU.sendFrame('{8'ha3, 8'h2e}, 16);
        checkVal(34'(backdropColour), 34'h2e, "frame after reset");
        $display("test done: reset in mid-run");
        stop_test();
    end
endmodule // osd_serial_command_decoder_bench
